//--- inc/dcf_pkg.sv
// Shared constants, types and the default offset table of the core.
// Assumes a single system clock; no file here holds logic.
package dcf_pkg;
   localparam int DATA_W    = 18;
   localparam int MEM_DEPTH = 8192;
   localparam int CNT_W     = 15;

   typedef logic [CNT_W-1:0] dcf_cnt_t;
   typedef logic [DATA_W-1:0] dcf_data_t;

   typedef enum logic {
      MODE_STD  = 1'b0,
      MODE_FALLTHROUGH_MODE = 1'b1
   } dcf_mode_t;

   // Capacity: memory alone, or memory plus the output register word
   localparam dcf_cnt_t STD_CAP      = dcf_cnt_t'(MEM_DEPTH);
   localparam dcf_cnt_t FALLTHROUGH_MODE_CAP     = dcf_cnt_t'(MEM_DEPTH + 1);
   localparam dcf_cnt_t HF_STD       = dcf_cnt_t'(MEM_DEPTH / 2 + 1);
   localparam dcf_cnt_t HF_FALLTHROUGH_MODE      = dcf_cnt_t'(MEM_DEPTH / 2 + 2);
   localparam dcf_cnt_t PAE_STD_ADD  = 15'h0001;
   localparam dcf_cnt_t PAE_FALLTHROUGH_MODE_ADD = 15'h0002;
   localparam dcf_cnt_t RST_OFFSET   = 15'h007f;
   localparam dcf_mode_t RST_MODE    = MODE_STD;
   localparam logic     RST_SYNC     = 1'b1;
   localparam logic     RST_SLOAD    = 1'b0;

   // Index is {load, select a, select b} as sampled during master reset
   function automatic dcf_cnt_t dcf_default_offset(input logic [2:0] sel);
      dcf_cnt_t off;
      unique case (sel)
         3'h4: off = 15'h03ff;
         3'h1: off = 15'h01ff;
         3'h2: off = 15'h00ff;
         3'h0: off = 15'h007f;
         3'h3: off = 15'h003f;
         3'h5: off = 15'h001f;
         3'h6: off = 15'h000f;
         3'h7: off = 15'h0007;
      endcase
      return off;
   endfunction : dcf_default_offset
endpackage : dcf_pkg

//--- inc/dcf_fifo_if.sv
// Handshake bundle between the flag logic and its word store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface dcf_fifo_if #(parameter int WIDTH = dcf_pkg::DATA_W);
   logic             clr;
   logic             wvalid;
   logic             wready;
   logic [WIDTH-1:0] wdata;
   logic             rvalid;
   logic             rready;
   logic [WIDTH-1:0] rdata;

   modport user  (output clr, wvalid, wdata, rready, input wready, rvalid, rdata);
   modport store (input clr, wvalid, wdata, rready, output wready, rvalid, rdata);
endinterface : dcf_fifo_if

//--- design/dcf_fifo.sv
// Word store with valid and ready on both sides.
// Assumes a power-of-two depth and a synchronous active-low reset.
`timescale 1ns/1ps
module dcf_fifo #(
   parameter int WIDTH = dcf_pkg::DATA_W,
   parameter int DEPTH = dcf_pkg::MEM_DEPTH
) (
   input wire logic  clk_i,
   input wire logic  rst_b_i,
   dcf_fifo_if.store fif
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_r;
   logic [AW:0]      rp_nxt;
   logic             full;
   logic             empty;
   logic             push;
   logic             pop;

   always_comb begin
      full   = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
      empty  = (wp_r == rp_r);
      push   = fif.wvalid && !full;
      pop    = fif.rready && !empty;
      wp_nxt = fif.clr ? '0 : wp_r + (AW+1)'(push);
      rp_nxt = fif.clr ? '0 : rp_r + (AW+1)'(pop);
   end

   assign fif.wready = !full;
   assign fif.rvalid = !empty;
   assign fif.rdata  = mem[rp_r[AW-1:0]];

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // Storage carries no reset, so it can map onto block memory
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= fif.wdata;
      end
   end

   a_no_overrun : assert property (@(posedge clk_i) disable iff (!rst_b_i)
      full && !pop && !fif.clr |=> wp_r == $past(wp_r))
      else $error("store accepted a word while full");
endmodule : dcf_fifo

//--- design/dcf_core.sv
// Mode, flag and output-register logic of the first-in first-out core.
// Assumes writer and reader both run on SYS_CLK_I and keep their enables.
`timescale 1ns/1ps
// Overview of operation
// - Master reset with timing select high picks fall-through mode.
// - Master reset with timing select low picks standard mode.
// - Fall-through: first word shows, output valid low, three edges after write.
// - Write enable low stores input data on the clock edge.
// - Fall-through almost-empty goes high at n plus two words.
// - Fall-through half-full goes low at D/2+2 words.
// - Fall-through almost-full goes low at D plus one minus m words.
// - Fall-through input-ready goes high, blocking writes, after D plus one writes.
// - Fall-through: first read from full drops input-ready after two edges.
// - Fall-through almost-empty goes low at n plus one words.
// - Fall-through output valid goes high after last read; reads then ignored.
// - Output valid has three register stages, input ready two.
// - Standard: empty flag goes high two edges after first write.
// - Standard almost-empty goes high at n plus one words.
// - Standard half-full goes low at D/2+1 words.
// - Standard almost-full goes low at D minus m words.
// - Standard full goes low, blocking writes, after D writes.
// - Standard: first read from full raises full flag after two edges.
// - Standard almost-empty goes low with exactly n words stored.
// - Standard empty goes low after last read; reads then ignored.
// - Standard empty and full flags pass two register stages.
// - Master reset picks default offsets and serial or parallel loading.
// - Flag timing select picks one-sided or set/clear split flag updates.
module dcf_core (
   input  wire logic                     SYS_CLK_I,
   input  wire logic                     RST_B_I,
   input  wire logic                     MASTER_RESET_N_I,
   input  wire logic                     TIMING_SELECT_SERIAL_IN_I,
   input  wire logic                     FLAG_TIMING_SELECT_I,
   input  wire logic                     OFFSET_LOAD_N_I,
   input  wire logic                     OFFSET_SELECT_A_I,
   input  wire logic                     OFFSET_SELECT_B_I,
   input  wire logic                     WRITE_ENABLE_N_I,
   input  wire logic [dcf_pkg::DATA_W-1:0] DATA_IN_I,
   input  wire logic                     READ_ENABLE_N_I,
   output logic      [dcf_pkg::DATA_W-1:0] DATA_OUT_O,
   output logic                          FULL_FLAG_N_O,
   output logic                          INPUT_READY_N_O,
   output logic                          EMPTY_FLAG_N_O,
   output logic                          OUTPUT_VALID_N_O,
   output logic                          ALMOST_EMPTY_N_O,
   output logic                          ALMOST_FULL_N_O,
   output logic                          HALF_FULL_N_O,
   output logic                          FALLTHROUGH_MODE_O,
   output logic                          SERIAL_LOAD_O
);
   import dcf_pkg::*;

   dcf_fifo_if #(.WIDTH(DATA_W)) fif ();

   // Configuration latched during master reset
   dcf_mode_t mode_r;
   dcf_mode_t mode_nxt;
   logic      sync_r;
   logic      sync_nxt;
   logic      sload_r;
   logic      sload_nxt;
   dcf_cnt_t  off_r;
   dcf_cnt_t  off_nxt;

   // Write side
   dcf_cnt_t  wr_ptr_r;
   dcf_cnt_t  wr_ptr_nxt;
   dcf_cnt_t  rs1_r;
   dcf_cnt_t  rs1_nxt;
   logic      ovw_r;
   logic      ovw_nxt;
   logic      blk_r;
   logic      blk_nxt;
   logic      wr_acc;
   dcf_cnt_t  wtot;

   // Read side
   dcf_cnt_t  rd_ptr_r;
   dcf_cnt_t  rd_ptr_nxt;
   dcf_cnt_t  ws1_r;
   dcf_cnt_t  ws1_nxt;
   logic      ne_r;
   logic      ne_nxt;
   logic      ov_r;
   logic      ov_nxt;
   dcf_data_t dout_r;
   dcf_data_t dout_nxt;
   logic      want;
   logic      rd_pop;
   dcf_cnt_t  rtot;

   // Programmable flags
   logic      pae_n_r;
   logic      pae_n_nxt;
   logic      paf_n_r;
   logic      paf_n_nxt;
   logic      hf_n_r;
   logic      hf_n_nxt;

   logic      mrst;
   logic      fallthrough_mode;
   dcf_cnt_t  paf_thr;
   dcf_cnt_t  pae_thr;
   dcf_cnt_t  hf_thr;
   logic      paf_hit_w;
   logic      paf_hit_r;
   logic      pae_hit_w;
   logic      pae_hit_r;
   logic      hf_hit;

   assign mrst = !MASTER_RESET_N_I;
   assign fallthrough_mode = (mode_r == MODE_FALLTHROUGH_MODE);

   always_comb begin
      mode_nxt  = mode_r;
      sync_nxt  = sync_r;
      sload_nxt = sload_r;
      off_nxt   = off_r;
      if (mrst) begin
         mode_nxt  = TIMING_SELECT_SERIAL_IN_I ? MODE_FALLTHROUGH_MODE : MODE_STD;
         sync_nxt  = FLAG_TIMING_SELECT_I;
         sload_nxt = OFFSET_LOAD_N_I;
         off_nxt   = dcf_default_offset({OFFSET_LOAD_N_I, OFFSET_SELECT_A_I,
                                         OFFSET_SELECT_B_I});
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         mode_r  <= RST_MODE;
         sync_r  <= RST_SYNC;
         sload_r <= RST_SLOAD;
         off_r   <= RST_OFFSET;
      end else begin
         mode_r  <= mode_nxt;
         sync_r  <= sync_nxt;
         sload_r <= sload_nxt;
         off_r   <= off_nxt;
      end
   end

   // Thresholds; fall-through counts include the output register word
   always_comb begin
      paf_thr = (fallthrough_mode ? FALLTHROUGH_MODE_CAP : STD_CAP) - off_r;
      hf_thr  = fallthrough_mode ? HF_FALLTHROUGH_MODE : HF_STD;
      pae_thr = off_r + (fallthrough_mode ? PAE_FALLTHROUGH_MODE_ADD : PAE_STD_ADD);
   end

   // Write side: read pointer arrives through one sync stage
   always_comb begin
      wr_acc     = !WRITE_ENABLE_N_I && !blk_r && fif.wready && !mrst;
      wr_ptr_nxt = mrst ? '0 : wr_ptr_r + dcf_cnt_t'(wr_acc);
      rs1_nxt    = mrst ? '0 : rd_ptr_r;
      ovw_nxt    = mrst ? 1'b0 : ov_r;
      // Stale read pointer only overstates fill, so blocking stays safe
      blk_nxt    = !mrst && ((wr_ptr_nxt - rs1_r) >= STD_CAP);
      wtot       = wr_ptr_nxt - rs1_r + dcf_cnt_t'(ovw_r);
      paf_hit_w  = wtot >= paf_thr;
      pae_hit_w  = wtot >= pae_thr;
      hf_hit     = wtot >= hf_thr;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         wr_ptr_r <= '0;
         rs1_r    <= '0;
         ovw_r    <= 1'b0;
         blk_r    <= 1'b0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rs1_r    <= rs1_nxt;
         ovw_r    <= ovw_nxt;
         blk_r    <= blk_nxt;
      end
   end

   // Read side: write pointer arrives through one sync stage
   always_comb begin
      want       = fallthrough_mode ? (!ov_r || !READ_ENABLE_N_I) : !READ_ENABLE_N_I;
      rd_pop     = ne_r && want && fif.rvalid && !mrst;
      rd_ptr_nxt = mrst ? '0 : rd_ptr_r + dcf_cnt_t'(rd_pop);
      ws1_nxt    = mrst ? '0 : wr_ptr_r;
      ne_nxt     = !mrst && (ws1_r != rd_ptr_nxt);
      ov_nxt     = ov_r;
      if (mrst || !fallthrough_mode) begin
         ov_nxt = 1'b0;
      end else if (rd_pop) begin
         ov_nxt = 1'b1;
      end else if (!READ_ENABLE_N_I) begin
         ov_nxt = 1'b0;
      end
      dout_nxt   = mrst ? '0 : (rd_pop ? fif.rdata : dout_r);
      rtot       = ws1_r - rd_ptr_nxt + dcf_cnt_t'(ov_nxt);
      pae_hit_r  = rtot >= pae_thr;
      paf_hit_r  = rtot >= paf_thr;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         rd_ptr_r <= '0;
         ws1_r    <= '0;
         ne_r     <= 1'b0;
         ov_r     <= 1'b0;
         dout_r   <= '0;
      end else begin
         rd_ptr_r <= rd_ptr_nxt;
         ws1_r    <= ws1_nxt;
         ne_r     <= ne_nxt;
         ov_r     <= ov_nxt;
         dout_r   <= dout_nxt;
      end
   end

   // Split timing: almost-full asserts from the write side, almost-empty from the read side; the other side releases
   always_comb begin
      pae_n_nxt = pae_n_r;
      paf_n_nxt = paf_n_r;
      hf_n_nxt  = !hf_hit;
      if (mrst) begin
         pae_n_nxt = 1'b0;
         paf_n_nxt = 1'b1;
         hf_n_nxt  = 1'b1;
      end else if (sync_r) begin
         paf_n_nxt = !paf_hit_w;
         pae_n_nxt = pae_hit_r;
      end else begin
         if (paf_hit_w) begin
            paf_n_nxt = 1'b0;
         end else if (!paf_hit_r) begin
            paf_n_nxt = 1'b1;
         end
         if (!pae_hit_r) begin
            pae_n_nxt = 1'b0;
         end else if (pae_hit_w) begin
            pae_n_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_B_I) begin
         pae_n_r <= 1'b0;
         paf_n_r <= 1'b1;
         hf_n_r  <= 1'b1;
      end else begin
         pae_n_r <= pae_n_nxt;
         paf_n_r <= paf_n_nxt;
         hf_n_r  <= hf_n_nxt;
      end
   end

   assign fif.clr    = mrst;
   assign fif.wvalid = wr_acc;
   assign fif.wdata  = DATA_IN_I;
   assign fif.rready = rd_pop;

   dcf_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(MEM_DEPTH)
   ) u_store (
      .clk_i  (SYS_CLK_I),
      .rst_b_i(RST_B_I),
      .fif    (fif)
   );

   assign DATA_OUT_O         = dout_r;
   assign FULL_FLAG_N_O      = !blk_r;
   assign INPUT_READY_N_O    = blk_r;
   assign EMPTY_FLAG_N_O     = ne_r;
   assign OUTPUT_VALID_N_O   = !ov_r;
   assign ALMOST_EMPTY_N_O   = pae_n_r;
   assign ALMOST_FULL_N_O    = paf_n_r;
   assign HALF_FULL_N_O      = hf_n_r;
   assign FALLTHROUGH_MODE_O = fallthrough_mode;
   assign SERIAL_LOAD_O      = sload_r;

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_B_I || !MASTER_RESET_N_I);

   a_mode_latch : assert property (disable iff (!RST_B_I)
      !MASTER_RESET_N_I |=> FALLTHROUGH_MODE_O == $past(TIMING_SELECT_SERIAL_IN_I))
      else $error("mode not latched from timing select");

   a_fallthrough_mode_first_word : assert property (
      fallthrough_mode && wr_acc && wr_ptr_r == rd_ptr_r && !ov_r && !ne_r
      |-> OUTPUT_VALID_N_O [*4] ##1 !OUTPUT_VALID_N_O)
      else $error("first word not shown after three edges");

   a_std_empty_rise : assert property (
      !fallthrough_mode && wr_acc && wr_ptr_r == rd_ptr_r && !ne_r
      |-> !EMPTY_FLAG_N_O [*3] ##1 EMPTY_FLAG_N_O)
      else $error("empty flag not released two edges after write");

   a_full_blocks : assert property (
      blk_r |-> !fif.wvalid ##1 $stable(wr_ptr_r))
      else $error("write accepted while full");

   a_full_release : assert property (
      blk_r && rd_pop |-> ##1 !FULL_FLAG_N_O ##1 !FULL_FLAG_N_O ##1 FULL_FLAG_N_O)
      else $error("full flag not released two edges after read");

   a_empty_ignore : assert property (
      !ne_r && !READ_ENABLE_N_I |-> !rd_pop ##1 $stable(DATA_OUT_O))
      else $error("read taken while empty");

   a_ov_drop : assert property (
      fallthrough_mode && !OUTPUT_VALID_N_O && !READ_ENABLE_N_I && !ne_r |=> OUTPUT_VALID_N_O)
      else $error("output valid held after last read");

   a_pae_level : assert property (
      sync_r && $past(sync_r) && rtot == pae_thr |=> ALMOST_EMPTY_N_O)
      else $error("almost empty not released at threshold");

   a_paf_level : assert property (
      sync_r && wtot == paf_thr |=> !ALMOST_FULL_N_O)
      else $error("almost full not set at threshold");

   a_half_full : assert property (
      wtot == (fallthrough_mode ? HF_FALLTHROUGH_MODE : HF_STD) |=> !HALF_FULL_N_O)
      else $error("half full not set at threshold");

   a_half_clear : assert property (
      wtot == (fallthrough_mode ? HF_FALLTHROUGH_MODE : HF_STD) - dcf_cnt_t'(1) |=> HALF_FULL_N_O)
      else $error("half full set one word early");

   a_ir_release : assert property (
      fallthrough_mode && blk_r && rd_pop |-> ##1 INPUT_READY_N_O ##1 INPUT_READY_N_O ##1 !INPUT_READY_N_O)
      else $error("input ready not back two edges after read");

   a_std_empty_drop : assert property (
      !fallthrough_mode && rd_pop && ws1_r == rd_ptr_r + dcf_cnt_t'(1) |=> !EMPTY_FLAG_N_O)
      else $error("empty flag not set after last read");

   // Split timing: read side sets almost-empty, only the write side may release it
   a_pae_split_set : assert property (
      !sync_r && !pae_hit_r |=> !ALMOST_EMPTY_N_O)
      else $error("split almost empty not set from read side");

   a_pae_split_rel : assert property (
      !sync_r && pae_hit_r && pae_hit_w |=> ALMOST_EMPTY_N_O)
      else $error("split almost empty not released from write side");
endmodule : dcf_core

//--- bench/dcf_peer.sv
// Writer and reader model on the far side of the core's data ports.
// Assumes its tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module dcf_peer (
   input  wire logic               clk_i,
   input  wire logic               full_n_i,
   input  wire logic               ir_n_i,
   input  wire logic               empty_n_i,
   input  wire logic               ov_n_i,
   input  wire dcf_pkg::dcf_data_t dout_i,
   output logic                    we_n_o,
   output dcf_pkg::dcf_data_t      din_o,
   output logic                    re_n_o
);
   import dcf_pkg::*;
   logic      fallthrough_mode = 1'b0;
   int        n_wr = 0;
   int        n_rd = 0;
   dcf_data_t got[$];

   initial begin
      we_n_o = 1'b1;
      re_n_o = 1'b1;
      din_o  = '0;
   end

   function automatic dcf_data_t word(input int k);
      return dcf_data_t'(k) ^ 18'h2aaaa;
   endfunction : word

   // Gives up after a few refused edges, so a stuck flag cannot hang us
   task automatic write_burst(input int cnt);
      int   tries;
      logic ok;
      tries = cnt + 8;
      din_o = word(n_wr);
      we_n_o = 1'b0;
      while (cnt > 0 && tries > 0) begin
         ok = fallthrough_mode ? (ir_n_i === 1'b0) : (full_n_i === 1'b1);
         @(posedge clk_i);
         #1;
         tries--;
         if (ok) begin
            n_wr++;
            cnt--;
            din_o = word(n_wr);
         end
      end
      we_n_o = 1'b1;
      din_o  = ~din_o;
   endtask : write_burst

   // Fall-through shows the word before the consuming edge
   task automatic read_burst(input int cnt);
      int        tries;
      logic      ok;
      dcf_data_t early;
      tries = cnt + 8;
      re_n_o = 1'b0;
      while (cnt > 0 && tries > 0) begin
         ok = fallthrough_mode ? (ov_n_i === 1'b0) : (empty_n_i === 1'b1);
         early = dout_i;
         @(posedge clk_i);
         #1;
         tries--;
         if (ok) begin
            got.push_back(fallthrough_mode ? early : dout_i);
            n_rd++;
            cnt--;
         end
      end
      re_n_o = 1'b1;
   endtask : read_burst
endmodule : dcf_peer

//--- bench/test_dual_clock_fifo_flag_modes.sv
// Self-checking bench: fills, drains and times the flags in both modes.
// Assumes the peer model drives the data ports and the bench the config pins.
`timescale 1ns/1ps
module test_dual_clock_fifo_flag_modes;
   import dcf_pkg::*;
   localparam int LIMIT   = 60000;
   localparam int OFFS[8] = '{127, 511, 255, 63, 1023, 31, 15, 7};
   logic       clk    = 1'b0;
   logic       rst_b  = 1'b0;
   logic       mrst_n = 1'b1;
   logic       tsel   = 1'b0;
   logic       ftsel  = 1'b1;
   logic [2:0] sel    = 3'h0;
   logic       fw     = 1'b0;
   logic       we_n, re_n, ff_n, ir_n, ef_n, ov_n, pae_n, paf_n, hf_n, fmode, sload;
   dcf_data_t  din, dout;
   int         num_errors = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         rd_chk = 0;

   dcf_core dcf_core_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .MASTER_RESET_N_I(mrst_n),
      .TIMING_SELECT_SERIAL_IN_I(tsel), .FLAG_TIMING_SELECT_I(ftsel),
      .OFFSET_LOAD_N_I(sel[2]), .OFFSET_SELECT_A_I(sel[1]), .OFFSET_SELECT_B_I(sel[0]),
      .WRITE_ENABLE_N_I(we_n), .DATA_IN_I(din), .READ_ENABLE_N_I(re_n),
      .DATA_OUT_O(dout), .FULL_FLAG_N_O(ff_n), .INPUT_READY_N_O(ir_n),
      .EMPTY_FLAG_N_O(ef_n), .OUTPUT_VALID_N_O(ov_n), .ALMOST_EMPTY_N_O(pae_n),
      .ALMOST_FULL_N_O(paf_n), .HALF_FULL_N_O(hf_n), .FALLTHROUGH_MODE_O(fmode),
      .SERIAL_LOAD_O(sload));

   dcf_peer dcf_peer_inst (.clk_i(clk), .full_n_i(ff_n), .ir_n_i(ir_n), .empty_n_i(ef_n),
      .ov_n_i(ov_n), .dout_i(dout), .we_n_o(we_n), .din_o(din), .re_n_o(re_n));

   always #4 clk = ~clk;

   task automatic tally_and_finish;
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         num_errors++;
         $display("[FAIL] %0t run did not finish", $time);
         tally_and_finish();
      end
   end

   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask : fail

   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      n_compared++;
      if (got !== exp) fail(msg);
   endtask : cmp_bit

   task automatic cmp_data(input dcf_data_t got, input dcf_data_t exp);
      n_compared++;
      if (got !== exp) fail("data word");
   endtask : cmp_data

   // Mode-free vector {full, almost full_n, half full_n, almost empty_n, any word}
   task automatic cmp_flags(input logic [4:0] e);
      logic [4:0] got;
      logic [4:0] exp;
      got = fw ? {ir_n, paf_n, hf_n, pae_n, ov_n} : {ff_n, paf_n, hf_n, pae_n, ef_n};
      exp = fw ? {e[4], e[3:1], ~e[0]} : {~e[4], e[3:1], e[0]};
      n_compared++;
      if (got !== exp) fail("flag set");
   endtask : cmp_flags

   function automatic logic pick(input int w);
      case (w)
         0: return ef_n;
         1: return ov_n;
         2: return ff_n;
         default: return ir_n;
      endcase
   endfunction : pick

   // Flag must hold its old level for lat-1 edges, then flip
   task automatic lat_check(input int w, input int lat, input logic after);
      for (int k = 0; k <= lat; k++) begin
         cmp_bit(pick(w), (k == lat) ? after : ~after, "flag latency");
         if (k < lat) begin
            @(posedge clk);
            #1;
         end
      end
   endtask : lat_check

   task automatic mreset(input logic mode, input logic ft, input logic [2:0] s);
      mrst_n = 1'b0;
      tsel = mode;
      ftsel = ft;
      sel = s;
      repeat (2) @(posedge clk);
      #1;
      mrst_n = 1'b1;
      // Pins move after release; latched settings must not follow
      tsel = ~mode;
      sel = ~s;
      fw = mode;
      dcf_peer_inst.fallthrough_mode = mode;
      dcf_peer_inst.n_wr = 0;
      dcf_peer_inst.n_rd = 0;
      rd_chk = 0;
      @(posedge clk);
      #1;
      cmp_bit(fmode, mode, "mode latch");
      cmp_bit(sload, s[2], "load latch");
      cmp_flags(5'b01100);
   endtask : mreset

   task automatic goto(input int target, input logic [4:0] e);
      int occ;
      occ = dcf_peer_inst.n_wr - dcf_peer_inst.n_rd;
      if (target > occ) dcf_peer_inst.write_burst(target - occ);
      if (target < occ) dcf_peer_inst.read_burst(occ - target);
      repeat (4) @(posedge clk);
      #1;
      cmp_flags(e);
      while (dcf_peer_inst.got.size() > 0) begin
         cmp_data(dcf_peer_inst.got.pop_front(), dcf_peer_inst.word(rd_chk));
         rd_chk++;
      end
   endtask : goto

   task automatic run_mode(input logic mode);
      int x;
      x = mode ? 1 : 0; // Output register holds one extra word
      mreset(mode, 1'b1, 3'h7);
      dcf_peer_inst.write_burst(1);
      if (mode) lat_check(1, 3, 1'b0);
      else lat_check(0, 2, 1'b1);
      if (mode) cmp_data(dout, dcf_peer_inst.word(0));
      goto(7 + x, 5'b01101);
      goto(8 + x, 5'b01111);
      goto(4096 + x, 5'b01111);
      goto(4097 + x, 5'b01011);
      goto(8184 + x, 5'b01011);
      goto(8185 + x, 5'b00011);
      goto(8191 + x, 5'b00011);
      goto(8192 + x, 5'b10011);
      dcf_peer_inst.write_burst(1);
      cmp_bit(dcf_peer_inst.n_wr == 8192 + x, 1'b1, "write while full");
      dcf_peer_inst.read_burst(1);
      lat_check(mode ? 3 : 2, 2, ~mode);
      goto(4097 + x, 5'b01011);
      goto(4096 + x, 5'b01111);
      goto(8 + x, 5'b01111);
      goto(7 + x, 5'b01101);
      goto(0, 5'b01100);
      dcf_peer_inst.read_burst(1);
      cmp_flags(5'b01100);
      if (!mode) cmp_data(dout, dcf_peer_inst.word(dcf_peer_inst.n_wr - 1));
   endtask : run_mode

   initial begin
      repeat (6) @(posedge clk);
      #1;
      rst_b = 1'b1;
      run_mode(1'b0);
      run_mode(1'b1);
      for (int s = 0; s < 8; s++) begin
         mreset(1'b0, s[0], 3'(s));
         goto(OFFS[s], 5'b01101);
         goto(OFFS[s] + 1, 5'b01111);
      end
      tally_and_finish();
   end
endmodule : test_dual_clock_fifo_flag_modes
